// [common/arp_defs.svh]
// Constants of the acceleration result path and start-up sequencer
// ==========================================================
// Overview of operation
// - Above full scale, within limits: overrange
// - Filter at sinc maximum: overflow, clip
// - Normal results return once input valid
// - Negative side uses underrange and underflow
// - Freeze input high blocks buffer updates
// - Processor keeps sampling regardless of freeze
// - Frozen reads return values at rising edge
// - Power-up enters normal mode by default
// - Reset held until three supplies good
// - Phase one copies fuses, then powers off
// - Phase two settles reference, maybe highpass
// - Phase one ignores serial accesses silently
// - Phase two: registers work, acceleration doesn't
// - Phase one lasts about 800 us
// - Phase two 3 ms, or 200 ms highpass
// - Init pending set by reset, cleared later
// - Five-bit lowpass code selects cutoff, sample
// - Linear words span -509 to +508
`ifndef ARP_DEFS_SVH
`define ARP_DEFS_SVH

// ==========================================================
// Timing
`define ARP_CLK_MHZ 50
`define ARP_PH1_US 800
`define ARP_PH2_MS 3
`define ARP_PH2_HPF_MS 200
`define ARP_PH1_CYC (`ARP_PH1_US * `ARP_CLK_MHZ)
`define ARP_PH2_CYC (`ARP_PH2_MS * 1000 * `ARP_CLK_MHZ)
`define ARP_PH2_HPF_CYC (`ARP_PH2_HPF_MS * 1000 * `ARP_CLK_MHZ)

// ==========================================================
// Register byte offsets
`define ARP_OFS_CFG 8'h00
`define ARP_OFS_STAT 8'h04
`define ARP_OFS_IRQ 8'h08
`define ARP_OFS_MASK 8'h0C
`define ARP_OFS_RES_X 8'h10
`define ARP_OFS_RES_Y 8'h14
`define ARP_OFS_MIRROR 8'h18

// ==========================================================
// Field positions and reset values
`define ARP_CFG_X_LSB 0
`define ARP_CFG_Y_LSB 5
`define ARP_CFG_HPF_BIT 10
`define ARP_CFG_RST 11'h000
`define ARP_STAT_INIT_BIT 0
`define ARP_STAT_PH2_BIT 1
`define ARP_STAT_TEST_BIT 2
`define ARP_STAT_FRZ_BIT 3
`define ARP_IRQ_DONE_BIT 8
`define ARP_MASK_RST 9'h000

// ==========================================================
// Data range limits and condition codes
`define ARP_LIN_MAX 12'sh1FC
`define ARP_LIN_MIN 12'shE03
`define ARP_SINC_MAX 12'sh7FF
`define ARP_SINC_MIN 12'sh800
`define ARP_CODE_ORANGE 10'h1FD
`define ARP_CODE_OFLOW 10'h1FE
`define ARP_CODE_URANGE 10'h202
`define ARP_CODE_UFLOW 10'h201
`define ARP_NOT_ACCEL 16'h8000

`endif

// [common/arp_pkg.sv]
// Types of the acceleration result path and start-up sequencer
package arp_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ARP_ST_POR = 4'h1,
    ARP_ST_FUSE = 4'h2,
    ARP_ST_REF = 4'h4,
    ARP_ST_RUN = 4'h8
  } arp_state_t;

  // Classified result: output word and events {uflow, urange, oflow, orange}
  typedef struct packed {
    logic [9:0] code;
    logic [3:0] ev;
  } arp_res_t;

endpackage

// [src/arp_top.sv]
// Result classification, freeze, start-up sequencing and AXI4-Lite registers
`include "arp_defs.svh"

module arp_top
  import arp_pkg::*;
#(
  parameter int unsigned PH1_CYC = `ARP_PH1_CYC,
  parameter int unsigned PH2_CYC = `ARP_PH2_CYC,
  parameter int unsigned PH2_HPF_CYC = `ARP_PH2_HPF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  input wire logic dsp_clk,
  input wire logic [11:0] dsp_x,
  input wire logic [11:0] dsp_y,
  input wire logic result_freeze_input,
  input wire logic [2:0] supply_good,
  input wire logic programming_supply_pin,
  input wire logic [15:0] fuse_data,
  output logic fuse_power,
  output logic hpf_init,
  input wire logic host_req,
  input wire logic host_accel,
  input wire logic host_axis,
  output logic host_resp_valid,
  output logic [15:0] host_resp_data,
  output logic [8:0] x_sample_us,
  output logic [8:0] y_sample_us,
  output logic [9:0] x_cutoff_hz,
  output logic [9:0] y_cutoff_hz,
  output logic x_four_pole,
  output logic y_four_pole
);

  // ==========================================================
  // Functions

  // Maps a filter output word to the 10-bit result word and its events
  function automatic arp_res_t classify(input logic signed [11:0] v);
    arp_res_t r;
    r.ev = 4'h0;
    r.code = v[9:0];
    if (v >= `ARP_SINC_MAX) begin
      r.code = `ARP_CODE_OFLOW;
      r.ev = 4'h2;
    end else if (v > `ARP_LIN_MAX) begin
      r.code = `ARP_CODE_ORANGE;
      r.ev = 4'h1;
    end else if (v <= `ARP_SINC_MIN) begin
      r.code = `ARP_CODE_UFLOW;
      r.ev = 4'h8;
    end else if (v < `ARP_LIN_MIN) begin
      r.code = `ARP_CODE_URANGE;
      r.ev = 4'h4;
    end
    return r;
  endfunction

  // Sample time of a lowpass select code
  function automatic logic [8:0] sample_us(input logic [4:0] c);
    logic [8:0] t;
    t = 9'h010;
    if (c == 5'h00) begin
      t = 9'h100;
    end else if (c == 5'h01) begin
      t = 9'h080;
    end else if (c <= 5'h03 || c == 5'h13) begin
      t = 9'h040;
    end else if (c <= 5'h07 || (c >= 5'h14 && c <= 5'h19)) begin
      t = 9'h020;
    end
    return t;
  endfunction

  // Cutoff of a lowpass select code
  function automatic logic [9:0] cutoff_hz(input logic [4:0] c);
    logic [9:0] tab [0:31];
    tab = '{10'h00A, 10'h00F, 10'h01E, 10'h032, 10'h04B, 10'h064, 10'h082, 10'h0A0,
            10'h0C8, 10'h0FA, 10'h12C, 10'h15E, 10'h190, 10'h1F4, 10'h258, 10'h2BC,
            10'h320, 10'h384, 10'h3E8, 10'h00A, 10'h00F, 10'h01E, 10'h032, 10'h04B,
            10'h064, 10'h082, 10'h0A0, 10'h0C8, 10'h0FA, 10'h12C, 10'h15E, 10'h190};
    return tab[c];
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [2:0] clk_sy;
  logic [1:0] frz_sy;
  logic [1:0] prog_sy;
  logic [2:0] sup_s1;
  logic [2:0] sup_s2;
  logic [11:0] x_s1;
  logic [11:0] x_s2;
  logic [11:0] y_s1;
  logic [11:0] y_s2;
  logic [15:0] fuse_s1;
  logic [15:0] fuse_s2;
  logic dsp_edge;
  logic freeze;

  // Two flops per pin; third flop of the clock only for edge finding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sy <= 3'h0;
      frz_sy <= 2'h0;
      prog_sy <= 2'h0;
      sup_s1 <= 3'h0;
      sup_s2 <= 3'h0;
      x_s1 <= 12'h000;
      x_s2 <= 12'h000;
      y_s1 <= 12'h000;
      y_s2 <= 12'h000;
      fuse_s1 <= 16'h0000;
      fuse_s2 <= 16'h0000;
    end else begin
      clk_sy <= {clk_sy[1:0], dsp_clk};
      frz_sy <= {frz_sy[0], result_freeze_input};
      prog_sy <= {prog_sy[0], programming_supply_pin};
      sup_s1 <= supply_good;
      sup_s2 <= sup_s1;
      x_s1 <= dsp_x;
      x_s2 <= x_s1;
      y_s1 <= dsp_y;
      y_s2 <= y_s1;
      fuse_s1 <= fuse_data;
      fuse_s2 <= fuse_s1;
    end
  end

  assign dsp_edge = clk_sy[1] & ~clk_sy[2];
  assign freeze = frz_sy[1];

  // ==========================================================
  // Start-up sequencer
  arp_state_t state, next_state;
  logic [23:0] cnt, next_cnt;
  logic [15:0] mirror, next_mirror;
  logic test_mode, next_test_mode;
  logic init_pending, next_init_pending;
  logic hpf_sel;
  logic init_done_ev;
  logic ph2_len_hit;

  assign ph2_len_hit = hpf_sel ? (cnt >= 24'(PH2_HPF_CYC - 1)) : (cnt >= 24'(PH2_CYC - 1));

  // Next state of the sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt + 24'h000001;
    next_mirror = mirror;
    next_test_mode = test_mode;
    next_init_pending = init_pending;
    init_done_ev = 1'b0;
    unique case (state)
      ARP_ST_POR: begin
        next_cnt = 24'h000000;
        next_init_pending = 1'b1;
        if (&sup_s2) begin
          next_state = ARP_ST_FUSE;
          next_test_mode = prog_sy[1];
        end
      end
      ARP_ST_FUSE: begin
        if (cnt >= 24'(PH1_CYC - 1)) begin
          next_mirror = fuse_s2;
          next_state = ARP_ST_REF;
          next_cnt = 24'h000000;
        end
      end
      ARP_ST_REF: begin
        if (ph2_len_hit) begin
          next_state = ARP_ST_RUN;
          next_init_pending = 1'b0;
          init_done_ev = 1'b1;
          next_cnt = 24'h000000;
        end
      end
      ARP_ST_RUN: begin
        next_cnt = cnt;
      end
      default: begin
        next_state = ARP_ST_POR;
      end
    endcase
    if (!(&sup_s2)) begin
      next_state = ARP_ST_POR;
    end
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ARP_ST_POR;
      cnt <= 24'h000000;
      mirror <= 16'h0000;
      test_mode <= 1'b0;
      init_pending <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mirror <= next_mirror;
      test_mode <= next_test_mode;
      init_pending <= next_init_pending;
    end
  end

  assign fuse_power = (state == ARP_ST_FUSE);
  assign hpf_init = (state == ARP_ST_REF) & hpf_sel;

  // ==========================================================
  // Result path: classification runs always, buffers obey freeze
  arp_res_t res_x, res_y;
  logic [9:0] buf_x, next_buf_x;
  logic [9:0] buf_y, next_buf_y;
  logic [7:0] range_ev;

  // Classify every processor sample; condition lasts only that sample
  always_comb begin
    res_x = classify(x_s2);
    res_y = classify(y_s2);
    range_ev = dsp_edge ? {res_y.ev, res_x.ev} : 8'h00;
    next_buf_x = buf_x;
    next_buf_y = buf_y;
    if (dsp_edge && !freeze) begin
      next_buf_x = res_x.code;
      next_buf_y = res_y.code;
    end
  end

  // Serial result buffers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_x <= 10'h000;
      buf_y <= 10'h000;
    end else begin
      buf_x <= next_buf_x;
      buf_y <= next_buf_y;
    end
  end

  // ==========================================================
  // Serial host requests
  logic rsp_v, next_rsp_v;
  logic [15:0] rsp_d, next_rsp_d;
  logic [10:0] cfg;
  logic [15:0] status_word;

  assign status_word = {12'h000, freeze, test_mode, (state == ARP_ST_REF), init_pending};

  // Answer one cycle after a request, silent in phase one
  always_comb begin
    next_rsp_v = 1'b0;
    next_rsp_d = rsp_d;
    if (host_req && (state == ARP_ST_REF || state == ARP_ST_RUN)) begin
      next_rsp_v = 1'b1;
      if (!host_accel) begin
        next_rsp_d = status_word;
      end else if (state == ARP_ST_REF) begin
        next_rsp_d = `ARP_NOT_ACCEL | status_word;
      end else begin
        next_rsp_d = {6'h00, host_axis ? buf_y : buf_x};
      end
    end
  end

  // Host answer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_v <= 1'b0;
      rsp_d <= 16'h0000;
    end else begin
      rsp_v <= next_rsp_v;
      rsp_d <= next_rsp_d;
    end
  end

  assign host_resp_valid = rsp_v;
  assign host_resp_data = rsp_d;

  // ==========================================================
  // AXI4-Lite slave and interrupt registers
  logic aw_hold, next_aw_hold;
  logic w_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bv, next_bv;
  logic [1:0] br, next_br;
  logic rv, next_rv;
  logic [31:0] rd, next_rd;
  logic [1:0] rr, next_rr;
  logic [10:0] next_cfg;
  logic [8:0] irq_st, next_irq_st;
  logic [8:0] irq_mask, next_irq_mask;
  logic do_wr;

  assign hpf_sel = cfg[`ARP_CFG_HPF_BIT];
  assign do_wr = aw_hold & w_hold & ~bv;

  // Bus handshakes, register writes and sticky events
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bv = bv;
    next_br = br;
    next_rv = rv;
    next_rd = rd;
    next_rr = rr;
    next_cfg = cfg;
    next_irq_mask = irq_mask;
    next_irq_st = irq_st;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bv && s_axi_bready) begin
      next_bv = 1'b0;
    end
    if (do_wr) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bv = 1'b1;
      next_br = 2'h0;
      unique case (aw_addr)
        `ARP_OFS_CFG: begin
          if (w_strb[0]) next_cfg[7:0] = w_data[7:0];
          if (w_strb[1]) next_cfg[10:8] = w_data[10:8];
        end
        `ARP_OFS_IRQ: begin
          if (w_strb[0]) next_irq_st[7:0] = irq_st[7:0] & ~w_data[7:0];
          if (w_strb[1]) next_irq_st[8] = irq_st[8] & ~w_data[8];
        end
        `ARP_OFS_MASK: begin
          if (w_strb[0]) next_irq_mask[7:0] = w_data[7:0];
          if (w_strb[1]) next_irq_mask[8] = w_data[8];
        end
        `ARP_OFS_STAT, `ARP_OFS_RES_X, `ARP_OFS_RES_Y, `ARP_OFS_MIRROR: begin
          next_br = 2'h0;
        end
        default: begin
          next_br = 2'h3;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    next_irq_st = next_irq_st | {init_done_ev, range_ev};
    if (rv && s_axi_rready) begin
      next_rv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rv = 1'b1;
      next_rr = 2'h0;
      next_rd = 32'h00000000;
      unique case (s_axi_araddr)
        `ARP_OFS_CFG: next_rd = {21'h000000, cfg};
        `ARP_OFS_STAT: next_rd = {16'h0000, status_word};
        `ARP_OFS_IRQ: next_rd = {23'h000000, irq_st};
        `ARP_OFS_MASK: next_rd = {23'h000000, irq_mask};
        `ARP_OFS_RES_X: next_rd = {{22{buf_x[9]}}, buf_x};
        `ARP_OFS_RES_Y: next_rd = {{22{buf_y[9]}}, buf_y};
        `ARP_OFS_MIRROR: next_rd = {16'h0000, mirror};
        default: next_rr = 2'h3;
      endcase
    end
  end

  // Bus and interrupt registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bv <= 1'b0;
      br <= 2'h0;
      rv <= 1'b0;
      rd <= 32'h00000000;
      rr <= 2'h0;
      cfg <= `ARP_CFG_RST;
      irq_st <= 9'h000;
      irq_mask <= `ARP_MASK_RST;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bv <= next_bv;
      br <= next_br;
      rv <= next_rv;
      rd <= next_rd;
      rr <= next_rr;
      cfg <= next_cfg;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
    end
  end

  assign s_axi_awready = ~aw_hold & ~bv;
  assign s_axi_wready = ~w_hold & ~bv;
  assign s_axi_bvalid = bv;
  assign s_axi_bresp = br;
  assign s_axi_arready = ~rv;
  assign s_axi_rvalid = rv;
  assign s_axi_rdata = rd;
  assign s_axi_rresp = rr;
  assign irq = |(irq_st & irq_mask);

  // ==========================================================
  // Lowpass select decode per axis
  assign x_sample_us = sample_us(cfg[`ARP_CFG_X_LSB +: 5]);
  assign y_sample_us = sample_us(cfg[`ARP_CFG_Y_LSB +: 5]);
  assign x_cutoff_hz = cutoff_hz(cfg[`ARP_CFG_X_LSB +: 5]);
  assign y_cutoff_hz = cutoff_hz(cfg[`ARP_CFG_Y_LSB +: 5]);
  assign x_four_pole = (cfg[`ARP_CFG_X_LSB +: 5] <= 5'h12);
  assign y_four_pole = (cfg[`ARP_CFG_Y_LSB +: 5] <= 5'h12);

endmodule

// [verif/arp_host_model.sv]
// Serial host model: one-cycle requests, answer taken in its single cycle
module arp_host_model (
  input wire logic aclk,
  output logic host_req,
  output logic host_accel,
  output logic host_axis,
  input wire logic host_resp_valid,
  input wire logic [15:0] host_resp_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle request lines
  initial begin
    host_req = 1'h0;
    host_accel = 1'h0;
    host_axis = 1'h0;
  end

  // Call right after a rising edge; answer stands one cycle after the taking edge
  task automatic ask(input logic accel, input logic axis, output logic got, output logic [15:0] data);
    host_accel <= accel;
    host_axis <= axis;
    host_req <= 1'h1;
    @(posedge aclk);
    host_req <= 1'h0;
    @(posedge aclk);
    got = host_resp_valid;
    data = host_resp_data;
  endtask
endmodule

// [verif/arp_top_properties.sv]
// Port-level checks of the result path and start-up sequencer
// ==========================================================
// Checker
module arp_top_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fuse_power,
  input wire logic hpf_init,
  input wire logic host_req,
  input wire logic host_resp_valid,
  input wire logic [15:0] host_resp_data,
  input wire logic [8:0] x_sample_us,
  input wire logic [9:0] x_cutoff_hz,
  input wire logic x_four_pole
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Host answers
  chk_resp_cause: assert property (host_resp_valid |-> $past(host_req))
    else $error("host answer without a request");
  chk_ph1_silent: assert property (fuse_power && $past(fuse_power) |-> !host_resp_valid)
    else $error("host answer during fuse copy");
  chk_resp_hold: assert property (!host_resp_valid |-> $stable(host_resp_data))
    else $error("host data moved without an answer");
  // Start-up phases
  chk_phase_excl: assert property (!(fuse_power && hpf_init))
    else $error("highpass init during fuse copy");
  // Register bus
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  // Filter decode
  chk_fast_sample: assert property (x_four_pole && x_cutoff_hz >= 10'h0C8 |-> x_sample_us == 9'h010)
    else $error("fast cutoff without short sample time");

  // Main scenarios
  cov_hpf: cover property (hpf_init);
  cov_answer: cover property (host_resp_valid);
  cov_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule

bind arp_top arp_top_properties chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .fuse_power, .hpf_init, .host_req, .host_resp_valid, .host_resp_data,
  .x_sample_us, .x_cutoff_hz, .x_four_pole);

// [verif/tb.sv]
// Testbench of the result path and start-up sequencer
`include "arp_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PH1 = 20;
  localparam int PH2 = 40;
  localparam int PHH = 80;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, dsp_clk, result_freeze_input;
  logic programming_supply_pin, fuse_power, hpf_init, host_req, host_accel, host_axis, host_resp_valid;
  logic x_four_pole, y_four_pole, got;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [11:0] dsp_x, dsp_y;
  logic [2:0] supply_good;
  logic [15:0] fuse_data, host_resp_data, hd;
  logic [8:0] x_sample_us, y_sample_us;
  logic [9:0] x_cutoff_hz, y_cutoff_hz;
  logic [11:0] vin [9] = '{12'h1FC, 12'h1FD, 12'h7FE, 12'h7FF, 12'h064, 12'hE03, 12'hE02, 12'h801, 12'h800};
  logic [9:0] vex [9] = '{10'h1FC, 10'h1FD, 10'h1FD, 10'h1FE, 10'h064, 10'h203, 10'h202, 10'h202, 10'h201};
  logic [4:0] lc [4] = '{5'h00, 5'h08, 5'h12, 5'h15};
  logic [8:0] ls [4] = '{9'h100, 9'h010, 9'h010, 9'h020};
  logic [9:0] lf [4] = '{10'h00A, 10'h0C8, 10'h3E8, 10'h01E};
  logic lp [4] = '{1'h1, 1'h1, 1'h1, 1'h0};
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int n;

  arp_top #(.PH1_CYC(PH1), .PH2_CYC(PH2), .PH2_HPF_CYC(PHH)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .dsp_clk, .dsp_x, .dsp_y, .result_freeze_input, .supply_good,
    .programming_supply_pin, .fuse_data, .fuse_power, .hpf_init, .host_req, .host_accel, .host_axis,
    .host_resp_valid, .host_resp_data, .x_sample_us, .y_sample_us, .x_cutoff_hz, .y_cutoff_hz,
    .x_four_pole, .y_four_pole);
  arp_host_model host_u (.aclk, .host_req, .host_accel, .host_axis, .host_resp_valid, .host_resp_data);

  // ==========================================================
  // Clocks and hang guard
  initial aclk = 1'h0;
  always #10 aclk = ~aclk;
  // Processor sample clock, offset from the bus clock
  initial begin
    dsp_clk = 1'h0;
    #3;
    forever #80 dsp_clk = ~dsp_clk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      give_verdict();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Write with both channels offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(nm, d, exp);
  endtask

  // New processor output, held over three sample periods
  task automatic setv(input logic [11:0] v);
    @(negedge dsp_clk);
    @(posedge aclk);
    dsp_x <= v;
    dsp_y <= v;
    repeat (24) @(posedge aclk);
  endtask

  // Length of the next high stretch of fuse power or highpass init
  task automatic span(input logic hp, output int k);
    k = 0;
    while ((hp ? hpf_init : fuse_power) !== 1'h1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    k = 0;
    while ((hp ? hpf_init : fuse_power) === 1'h1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    dsp_x = 12'h000;
    dsp_y = 12'h000;
    result_freeze_input = 1'h0;
    supply_good = 3'h0;
    programming_supply_pin = 1'h0;
    fuse_data = 16'hA5C3;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (10) @(posedge aclk);
    chk("fuse power idle", fuse_power, 1'h0);
    rdc("status por", `ARP_OFS_STAT, 32'h1);
    supply_good <= 3'h7;
    repeat (8) @(posedge aclk);
    chk("fuse power on", fuse_power, 1'h1);
    host_u.ask(1'h0, 1'h0, got, hd);
    chk("phase one answer", got, 1'h0);
    while (fuse_power === 1'h1) @(posedge aclk);
    n = cyc;
    host_u.ask(1'h1, 1'h0, got, hd);
    chk("phase two answer", got, 1'h1);
    chk("phase two accel", hd, 16'h8003);
    rdc("mirror", `ARP_OFS_MIRROR, {16'h0000, fuse_data});
    axw(`ARP_OFS_MASK, 32'h100, rr);
    rdc("mask", `ARP_OFS_MASK, 32'h100);
    do host_u.ask(1'h0, 1'h0, got, hd); while (hd[0] !== 1'h0 && cyc - n < 200);
    n = cyc - n;
    chk("phase two length", n >= PH2 - 2 && n <= PH2 + 8, 1'h1);
    repeat (2) @(posedge aclk);
    chk("irq done", irq, 1'h1);
    rdc("status run", `ARP_OFS_STAT, 32'h0);
    axw(`ARP_OFS_IRQ, 32'h100, rr);
    chk("irq cleared", irq, 1'h0);
    axw(`ARP_OFS_MASK, 32'h1, rr);
    // Classification of both axes across every range boundary
    for (int i = 0; i < 9; i++) begin
      setv(vin[i]);
      rd = {{22{vex[i][9]}}, vex[i]};
      rdc("x result", `ARP_OFS_RES_X, rd);
      rdc("y result", `ARP_OFS_RES_Y, rd);
      host_u.ask(1'h1, 1'h0, got, hd);
      chk("host x", hd, {6'h00, vex[i]});
      host_u.ask(1'h1, 1'h1, got, hd);
      chk("host y", hd, {6'h00, vex[i]});
      chk("irq orange", irq, i > 0);
    end
    setv(12'h000);
    rdc("events", `ARP_OFS_IRQ, 32'h0FF);
    axw(`ARP_OFS_IRQ, 32'h0FF, rr);
    rdc("events cleared", `ARP_OFS_IRQ, 32'h0);
    chk("irq low", irq, 1'h0);
    // Freeze holds the buffers while the processor keeps running
    setv(12'h064);
    result_freeze_input <= 1'h1;
    repeat (4) @(posedge aclk);
    rdc("freeze flag", `ARP_OFS_STAT, 32'h8);
    setv(12'h0C8);
    rdc("frozen x", `ARP_OFS_RES_X, 32'h64);
    result_freeze_input <= 1'h0;
    repeat (24) @(posedge aclk);
    rdc("thawed x", `ARP_OFS_RES_X, 32'hC8);
    // Lowpass code decode
    // Axes get different codes so a crossed field would show
    for (int i = 0; i < 4; i++) begin
      axw(`ARP_OFS_CFG, {22'h0, lc[3-i], lc[i]}, rr);
      chk("x sample", x_sample_us, ls[i]);
      chk("y sample", y_sample_us, ls[3-i]);
      chk("x cutoff", x_cutoff_hz, lf[i]);
      chk("y cutoff", y_cutoff_hz, lf[3-i]);
      chk("x poles", x_four_pole, lp[i]);
      chk("y poles", y_four_pole, lp[3-i]);
    end
    // Unmapped and read-only places
    axw(8'h1C, 32'h1, rr);
    chk("bad write resp", rr, 2'h3);
    axr(8'h1C, rd, rr);
    chk("bad read resp", rr, 2'h3);
    axw(`ARP_OFS_STAT, 32'hF, rr);
    chk("ro write resp", rr, 2'h0);
    rdc("status kept", `ARP_OFS_STAT, 32'h0);
    // One supply lost, then start-up again with highpass selected
    axw(`ARP_OFS_CFG, 32'h400, rr);
    supply_good <= 3'h5;
    programming_supply_pin <= 1'h1;
    repeat (6) @(posedge aclk);
    rdc("status relapse", `ARP_OFS_STAT, 32'h1);
    supply_good <= 3'h7;
    span(1'h0, n);
    chk("phase one length", n >= PH1 - 2 && n <= PH1 + 2, 1'h1);
    span(1'h1, n);
    chk("highpass length", n >= PHH - 2 && n <= PHH + 2, 1'h1);
    rdc("test mode", `ARP_OFS_STAT, 32'h4);
    give_verdict();
  end
endmodule
